// >>> sbt_break_tx.sv
`default_nettype none
module sbt_break_tx
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             bit_tick,
	input  wire sbt_pkg::sbt_ctrl_t ctrl,
	output logic                  tx_line,
	output sbt_pkg::sbt_stat_t    stat
);
	// ************************************************************
	// State
	// ************************************************************
	sbt_pkg::sbt_state_t state_reg, state_next;   // Frame state
	logic [3:0]          cnt_reg, cnt_next;       // Bit period in progress, from 1
	logic [3:0]          len_reg, len_next;       // Length of current frame
	logic                pend_reg, pend_next;     // Break request seen
	logic                ten_reg, ten_next;       // Previous enable
	logic                line_reg, line_next;     // Registered line
	logic [3:0]          len_sel;                 // Nominal break length
	logic                frame_end;               // Last bit of a frame

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb
	begin
		len_sel    = ctrl.word_long ? sbt_pkg::SBT_BRK_BITS_LONG
			: sbt_pkg::SBT_BRK_BITS_SHORT;
		frame_end  = bit_tick && (cnt_reg == len_reg);
		state_next = state_reg;
		cnt_next   = cnt_reg;
		len_next   = len_reg;
		ten_next   = ctrl.transmit_enable;
		// Latch a break request, held until a break starts
		pend_next  = pend_reg | ctrl.break_request_bit;
		line_next  = sbt_pkg::SBT_LINE_MARK;
		unique case (state_reg)
			sbt_pkg::SBT_ST_OFF:
			begin
				if (ctrl.transmit_enable)
				begin
					// Enable rising queues one idle frame
					state_next = sbt_pkg::SBT_ST_IDLE;
					cnt_next   = sbt_pkg::SBT_BIT_FIRST;
					len_next   = len_sel;
				end
			end
			sbt_pkg::SBT_ST_READY:
			begin
				if (!ctrl.transmit_enable)
					state_next = sbt_pkg::SBT_ST_OFF;
				else if (pend_reg && bit_tick)
				begin
					// Start on a bit boundary so length is exact
					state_next = sbt_pkg::SBT_ST_BREAK;
					cnt_next   = sbt_pkg::SBT_BIT_FIRST;
					len_next   = len_sel;
					pend_next  = ctrl.break_request_bit;
					line_next  = sbt_pkg::SBT_LINE_SPACE;
				end
			end
			sbt_pkg::SBT_ST_BREAK:
			begin
				// Follow the live request so a clear ends the chain on time
				pend_next = ctrl.break_request_bit;
				line_next = sbt_pkg::SBT_LINE_SPACE;
				if (bit_tick)
					cnt_next = cnt_reg + 4'h1;
				if (frame_end)
				begin
					line_next = sbt_pkg::SBT_LINE_MARK;
					cnt_next  = sbt_pkg::SBT_BIT_FIRST;
					if (ctrl.break_request_bit && ctrl.transmit_enable)
					begin
						// Back-to-back break while request held
						len_next  = len_sel;
						pend_next = ctrl.break_request_bit;
						line_next = sbt_pkg::SBT_LINE_SPACE;
					end
					else
						state_next = ctrl.transmit_enable ? sbt_pkg::SBT_ST_READY
							: sbt_pkg::SBT_ST_OFF;
				end
			end
			sbt_pkg::SBT_ST_IDLE:
			begin
				if (bit_tick)
					cnt_next = cnt_reg + 4'h1;
				if (frame_end)
				begin
					cnt_next   = sbt_pkg::SBT_BIT_FIRST;
					state_next = sbt_pkg::SBT_ST_READY;
				end
			end
		endcase
		// Enable rising in a cycle whose next state is ready: go off instead, so an idle frame is queued
		if (state_reg != sbt_pkg::SBT_ST_OFF && !ten_reg && ctrl.transmit_enable
			&& state_next == sbt_pkg::SBT_ST_READY)
			state_next = sbt_pkg::SBT_ST_OFF;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state_reg <= sbt_pkg::SBT_ST_OFF;
			cnt_reg   <= sbt_pkg::SBT_BIT_FIRST;
			len_reg   <= sbt_pkg::SBT_BRK_BITS_SHORT;
			pend_reg  <= 1'b0;
			ten_reg   <= 1'b0;
			line_reg  <= sbt_pkg::SBT_LINE_MARK;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			len_reg   <= len_next;
			pend_reg  <= pend_next;
			ten_reg   <= ten_next;
			line_reg  <= line_next;
		end
	end

	// Line output from a flip-flop, status decoded from the state register
	assign tx_line       = line_reg;
	assign stat.busy     = (state_reg == sbt_pkg::SBT_ST_BREAK)
		|| (state_reg == sbt_pkg::SBT_ST_IDLE);
	assign stat.in_break = (state_reg == sbt_pkg::SBT_ST_BREAK);
	assign stat.in_idle  = (state_reg == sbt_pkg::SBT_ST_IDLE);

	// ************************************************************
	// Checks
	// ************************************************************
	// Break holds line low
	break_low_a: assert property (@(posedge clk) disable iff (!rst_b)
		stat.in_break && $past(stat.in_break) |-> !tx_line)
		else $error("Line high during break");
	// Break never longer than the long nominal length
	break_len_a: assert property (@(posedge clk) disable iff (!rst_b)
		stat.in_break |-> cnt_reg <= sbt_pkg::SBT_BRK_BITS_LONG)
		else $error("Break too long");
	// Length follows select at start
	len_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == sbt_pkg::SBT_ST_READY && state_next == sbt_pkg::SBT_ST_BREAK
		|=> len_reg == (ctrl.word_long ? sbt_pkg::SBT_BRK_BITS_LONG
			: sbt_pkg::SBT_BRK_BITS_SHORT))
		else $error("Wrong break length");
	// Request leads to break when ready
	start_a: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == sbt_pkg::SBT_ST_READY && pend_reg && bit_tick
		&& ctrl.transmit_enable |=> stat.in_break)
		else $error("Break not started");
	// Enable rise from off gives idle
	idle_q_a: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == sbt_pkg::SBT_ST_OFF && ctrl.transmit_enable |=> stat.in_idle)
		else $error("Idle not queued");
	// Held request chains breaks
	chain_a: assert property (@(posedge clk) disable iff (!rst_b)
		stat.in_break && frame_end && ctrl.break_request_bit && ctrl.transmit_enable
		|=> stat.in_break)
		else $error("Break chain broken");
	// Idle line is mark
	idle_mark_a: assert property (@(posedge clk) disable iff (!rst_b)
		stat.in_idle |-> tx_line)
		else $error("Idle not mark");
	// Off line is mark
	off_mark_a: assert property (@(posedge clk) disable iff (!rst_b)
		state_reg == sbt_pkg::SBT_ST_OFF && $past(state_reg) == sbt_pkg::SBT_ST_OFF
		|-> tx_line)
		else $error("Off not mark");
	cov_brk: cover property (@(posedge clk) disable iff (!rst_b) $rose(stat.in_break));
	cov_idl: cover property (@(posedge clk) disable iff (!rst_b) $rose(stat.in_idle));
	cov_chn: cover property (@(posedge clk) disable iff (!rst_b)
		stat.in_break && frame_end ##1 stat.in_break);
endmodule : sbt_break_tx
`default_nettype wire

// >>> sbt_pkg.sv
`default_nettype none
package sbt_pkg;
	// ************************************************************
	// Frame lengths in bit periods and line levels
	// ************************************************************
	localparam logic [3:0] SBT_BRK_BITS_SHORT = 4'ha;   // Word length select 0
	localparam logic [3:0] SBT_BRK_BITS_LONG  = 4'hb;   // Word length select 1
	localparam logic [3:0] SBT_BIT_FIRST      = 4'h1;   // First bit of a frame
	localparam logic       SBT_LINE_MARK      = 1'h1;   // Idle line level
	localparam logic       SBT_LINE_SPACE     = 1'h0;   // Break line level

	// ************************************************************
	// Transmitter states
	// ************************************************************
	typedef enum logic [1:0]
	{
		SBT_ST_OFF   = 2'h0,
		SBT_ST_IDLE  = 2'h1,
		SBT_ST_READY = 2'h3,
		SBT_ST_BREAK = 2'h2
	} sbt_state_t;

	// Control inputs from software register
	typedef struct packed
	{
		logic transmit_enable;     // Transmitter on
		logic break_request_bit;   // Break requested
		logic word_long;           // Word length select
	} sbt_ctrl_t;

	// Status toward the rest of the interface
	typedef struct packed
	{
		logic busy;                // Frame in progress
		logic in_break;            // Break frame on the line
		logic in_idle;             // Idle frame on the line
	} sbt_stat_t;
endpackage : sbt_pkg
`default_nettype wire

// >>> sbt_rx_model.sv
`default_nettype none
module sbt_rx_model
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic bit_tick,
	input  wire logic tx_line,
	output var  int   brk_len,
	output var  int   brk_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	int run;   // Space bits in the current break
	// Samples the line once per bit and measures each space run
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			run <= 0;
			brk_len <= 0;
			brk_cnt <= 0;
		end
		else if (bit_tick && tx_line === 1'h0)
			run <= run + 1;
		else if (bit_tick && run > 0)
		begin
			brk_len <= run;
			brk_cnt <= brk_cnt + 1;
			run <= 0;
		end
	end
endmodule : sbt_rx_model
`default_nettype wire

// >>> sbt_break_tx_bench.sv
`default_nettype none
module sbt_break_tx_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk = 1'h0;   // System clock
	logic               rst_b = 1'h0;   // Reset, active low
	logic               bit_tick = 1'h0;   // Bit rate strobe
	logic [1:0]         div = 2'h0;   // Bit rate divider
	sbt_pkg::sbt_ctrl_t ctrl = '0;   // Software control
	logic               tx_line;   // Serial output
	sbt_pkg::sbt_stat_t stat;   // Status
	int                 brk_len;   // Last break length
	int                 brk_cnt;   // Breaks seen
	int                 err_count = 0;   // Mismatches
	int                 num_checks = 0;   // Comparisons
	sbt_break_tx dut (.clk(clk), .rst_b(rst_b), .bit_tick(bit_tick), .ctrl(ctrl),
		.tx_line(tx_line), .stat(stat));
	sbt_rx_model rx (.clk(clk), .rst_b(rst_b), .bit_tick(bit_tick), .tx_line(tx_line),
		.brk_len(brk_len), .brk_cnt(brk_cnt));
	// Clock at 100 MHz
	initial
	begin
		forever #5 clk = ~clk;
	end
	// One bit period is four clocks
	always @(posedge clk)
	begin
		div <= div + 2'h1;
		bit_tick <= (div == 2'h3);
	end
	// Counts and reports a comparison
	task chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'h1)
		begin
			err_count++;
			$display("mismatch %0t %s", $time, msg);
		end
	endtask : chk
	// Waits a bounded time for a break count
	task wait_cnt(input int target);
		int i;
		for (i = 0; i < 500 && brk_cnt < target; i++)
			@(posedge clk);
		chk(brk_cnt >= target, "break missing");
	endtask : wait_cnt
	// Toggles enable off then on and waits out the idle frame
	task do_idle;
		int i;
		@(posedge clk) ctrl.transmit_enable <= 1'h0;
		repeat (3) @(posedge clk);
		ctrl.transmit_enable <= 1'h1;
		repeat (2) @(posedge clk);
		#1 chk(stat.in_idle === 1'h1, "no idle frame");
		for (i = 0; i < 100 && stat.in_idle !== 1'h0; i++)
			@(posedge clk);
		#1 chk(tx_line === 1'h1 && stat.busy === 1'h0, "idle not mark");
	endtask : do_idle
	// Idle then one set-and-clear break of the selected length
	task t_single(input logic wl, input int n);
		int c0;
		ctrl.word_long <= wl;
		do_idle();
		c0 = brk_cnt;
		@(posedge clk) ctrl.break_request_bit <= 1'h1;
		@(posedge clk) ctrl.break_request_bit <= 1'h0;
		wait_cnt(c0 + 1);
		chk(brk_len === n, "break length");
		repeat (100) @(posedge clk);
		chk(brk_cnt === c0 + 1, "extra break");
	endtask : t_single
	// Request held: breaks keep coming, each nominal
	task t_repeat;
		int c0;
		ctrl.word_long <= 1'h0;
		do_idle();
		c0 = brk_cnt;
		@(posedge clk) ctrl.break_request_bit <= 1'h1;
		repeat (100) @(posedge clk);
		@(posedge clk) ctrl.break_request_bit <= 1'h0;
		// Chained breaks merge into one space run of whole breaks
		wait_cnt(c0 + 1);
		chk(brk_len % 10 == 0 && brk_len >= 20 && brk_len <= 40, "repeat length");
		repeat (150) @(posedge clk);
		chk(brk_cnt === c0 + 1, "extra repeat break");
		chk(tx_line === 1'h1 && stat.in_break === 1'h0, "line not released");
	endtask : t_repeat
	// Prints the verdict and ends the run
	task summarize;
		if (err_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		#1 chk(tx_line === 1'h1, "reset level");
		t_single(1'h0, 10);
		t_single(1'h1, 11);
		t_repeat();
		summarize();
	end
	// Watchdog
	initial
	begin
		#50000;
		err_count++;
		summarize();
	end
endmodule : sbt_break_tx_bench
`default_nettype wire
